// [core/ccds_host.sv]
`timescale 1ns/10ps
module ccds_host (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic dual_mode_i,
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire ccds_pkg::ccds_req_s req_i,
    output logic rsp_valid_o,
    output ccds_pkg::ccds_rsp_s rsp_o,
    output ccds_pkg::ccds_pins_s pins_o,
    input wire logic [ccds_pkg::DATA_W-1:0] data_lanes_i,
    output logic [ccds_pkg::DATA_W-1:0] data_lanes_o,
    output logic data_lanes_oe_o,
    input wire logic [ccds_pkg::PAR_W-1:0] parity_lanes_i,
    output logic [ccds_pkg::PAR_W-1:0] parity_lanes_o,
    output logic parity_lanes_oe_o
);
    import ccds_pkg::*;

    typedef enum {ST_IDLE, ST_SETUP, ST_LATCH, ST_HOLD, ST_WRITE, ST_READ,
                  ST_TURN} ccds_state_e;

    ccds_state_e state_ff;
    logic [3:0] cnt_ff;
    ccds_req_s req_ff;
    ccds_pins_s pins_ff;
    logic drive_ff;
    logic [DATA_W-1:0] d_sync1_ff, d_sync2_ff;
    logic [PAR_W-1:0] p_sync1_ff, p_sync2_ff;
    ccds_rsp_s rsp_ff;
    logic rsp_valid_ff;

    function automatic logic [1:0] enables_n(input logic dual,
                                             input logic [1:0] sel);
        // single array: both enables move as one signal
        enables_n = dual ? ~sel : {2{~|sel}}; // [R11] [R12] [R13]
    endfunction : enables_n

    assign req_ready_o = (state_ff == ST_IDLE);
    assign pins_o = pins_ff;
    assign data_lanes_o = req_ff.wdata;
    assign parity_lanes_o = req_ff.wpar; // [R14]
    assign data_lanes_oe_o = drive_ff;
    assign parity_lanes_oe_o = drive_ff;
    assign rsp_o = rsp_ff;
    assign rsp_valid_o = rsp_valid_ff;

    // read lanes pass two flops
    always_ff @(posedge ref_clk_i)
    begin
        d_sync1_ff <= data_lanes_i;
        d_sync2_ff <= d_sync1_ff;
        p_sync1_ff <= parity_lanes_i;
        p_sync2_ff <= p_sync1_ff;
    end

    // sequencer
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            req_ff <= '0;
        end
        else
        begin
            cnt_ff <= (cnt_ff == 4'h0) ? 4'h0 : cnt_ff - CNT_ONE;
            unique case (state_ff)
                ST_IDLE:
                    if (req_valid_i)
                    begin
                        req_ff <= req_i;
                        state_ff <= ST_SETUP;
                        cnt_ff <= 4'(ASETUP_CYC + ALE_CYC);
                    end
                ST_SETUP:
                    if (cnt_ff == 4'h0)
                    begin
                        state_ff <= ST_LATCH;
                        cnt_ff <= 4'(AHOLD_CYC);
                    end
                ST_LATCH:
                    if (cnt_ff == 4'h0)
                    begin
                        state_ff <= req_ff.write ? ST_WRITE : ST_READ;
                        cnt_ff <= req_ff.write ? 4'(WPULSE_CYC)
                                               : 4'(RACC_CYC + SYNC_CYC);
                    end
                ST_WRITE:
                    if (cnt_ff == 4'h0)
                    begin
                        state_ff <= ST_TURN;
                        cnt_ff <= 4'(HIZ_CYC);
                    end
                ST_READ:
                    if (cnt_ff == 4'h0)
                    begin
                        state_ff <= ST_TURN;
                        cnt_ff <= 4'(HIZ_CYC);
                    end
                ST_TURN:
                    if (cnt_ff == 4'h0)
                        state_ff <= ST_IDLE;
                default:
                    state_ff <= ST_IDLE;
            endcase
        end
    end

    // pin drive
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            pins_ff <= '0;
            pins_ff.addr_latch_open <= 1'b1;
            pins_ff.chip_enable_n <= 1'b1;
            pins_ff.lower_byte_select_n <= 1'b1;
            pins_ff.upper_byte_select_n <= 1'b1;
            pins_ff.bank_a_output_enable_n <= 1'b1;
            pins_ff.bank_b_output_enable_n <= 1'b1;
            pins_ff.bank_a_write_enable_n <= 1'b1;
            pins_ff.bank_b_write_enable_n <= 1'b1;
            drive_ff <= 1'b0;
        end
        else
        begin
            pins_ff.dual_mode <= dual_mode_i; // [R5]
            unique case (state_ff)
                ST_IDLE:
                begin
                    pins_ff.addr_latch_open <= 1'b1; // [R1]
                    if (req_valid_i)
                        pins_ff.word_address <= req_i.word_address;
                end
                ST_SETUP:
                    if (cnt_ff == 4'h0)
                        pins_ff.addr_latch_open <= 1'b0; // [R2]
                ST_LATCH:
                    if (cnt_ff == 4'h0)
                    begin
                        pins_ff.chip_enable_n <= 1'b0; // [R8]
                        pins_ff.lower_byte_select_n <= ~req_ff.byte_sel[0];
                        pins_ff.upper_byte_select_n <= ~req_ff.byte_sel[1];
                        if (req_ff.write)
                        begin
                            // output enables stay high during writes
                            {pins_ff.bank_b_write_enable_n,
                             pins_ff.bank_a_write_enable_n} <=
                                enables_n(pins_ff.dual_mode, req_ff.bank_sel);
                            drive_ff <= 1'b1; // [R19]
                        end
                        else
                        begin
                            {pins_ff.bank_b_output_enable_n,
                             pins_ff.bank_a_output_enable_n} <=
                                pins_ff.dual_mode ?
                                (req_ff.bank_sel[1] ? 2'h1 : 2'h2) : 2'h0;
                        end
                    end
                ST_WRITE, ST_READ:
                    if (cnt_ff == 4'h0)
                    begin
                        // chip enable ends the cycle first
                        pins_ff.chip_enable_n <= 1'b1; // [R20]
                        pins_ff.bank_a_output_enable_n <= 1'b1;
                        pins_ff.bank_b_output_enable_n <= 1'b1;
                    end
                ST_TURN:
                begin
                    pins_ff.bank_a_write_enable_n <= 1'b1;
                    pins_ff.bank_b_write_enable_n <= 1'b1;
                    pins_ff.lower_byte_select_n <= 1'b1;
                    pins_ff.upper_byte_select_n <= 1'b1;
                    drive_ff <= 1'b0;
                end
                default:
                    drive_ff <= 1'b0;
            endcase
        end
    end

    // read capture
    always_ff @(posedge ref_clk_i)
    begin
        if (reset_i)
        begin
            rsp_ff <= '0;
            rsp_valid_ff <= 1'b0;
        end
        else
        begin
            rsp_valid_ff <= (state_ff == ST_READ) && (cnt_ff == 4'h0);
            if ((state_ff == ST_READ) && (cnt_ff == 4'h0))
            begin
                // unselected lanes read as zero
                rsp_ff.rdata <= d_sync2_ff & {{8{req_ff.byte_sel[1]}},
                                              {8{req_ff.byte_sel[0]}}};
                rsp_ff.rpar <= p_sync2_ff & req_ff.byte_sel; // [R14]
            end
        end
    end

    chk_single_oe_tied: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) !pins_ff.dual_mode |->
        pins_ff.bank_a_output_enable_n == pins_ff.bank_b_output_enable_n)
        else $error("oe split in single mode"); // [R11]
    chk_dual_one_oe: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) pins_ff.dual_mode |->
        !(!pins_ff.bank_a_output_enable_n && !pins_ff.bank_b_output_enable_n))
        else $error("both oe low in dual mode"); // [R9]
    chk_no_drive_read: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) drive_ff |->
        pins_ff.bank_a_output_enable_n && pins_ff.bank_b_output_enable_n)
        else $error("drive while oe low"); // [R16]
    chk_latch_before_ce: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) $fell(pins_ff.chip_enable_n) |->
        !pins_ff.addr_latch_open)
        else $error("access with open latch"); // [R2]
    chk_ce_ends_write: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) $rose(pins_ff.chip_enable_n) && drive_ff |->
        !(pins_ff.bank_a_write_enable_n && pins_ff.bank_b_write_enable_n))
        else $error("write not chip-enable ended"); // [R20]
    chk_single_we_tied: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) !pins_ff.dual_mode |->
        pins_ff.bank_a_write_enable_n == pins_ff.bank_b_write_enable_n)
        else $error("we split in single mode"); // [R12]
    chk_read_resp: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) $fell(pins_ff.bank_a_output_enable_n) |->
        ##[1:8] rsp_valid_ff)
        else $error("read response late"); // [R16]
    chk_ready_idle: assert property (@(posedge ref_clk_i)
        disable iff (reset_i) req_ready_o |-> pins_ff.chip_enable_n)
        else $error("ready while enabled"); // [R8]
    cov_write: cover property (@(posedge ref_clk_i) $rose(drive_ff));
    cov_read: cover property (@(posedge ref_clk_i) rsp_valid_ff);
    cov_both: cover property (@(posedge ref_clk_i)
        !pins_ff.bank_a_write_enable_n && !pins_ff.bank_b_write_enable_n);
endmodule : ccds_host

// [inc/ccds_pkg.sv]
// Functional notes
// [R1] latch open: internal address follows pins
// [R2] falling latch edge captures thirteen address bits
// [R3] single array: top bit picks half
// [R4] two banks: top address bit ignored
// [R5] config pin high two banks, low one
// [R6] lower select low enables lower lane
// [R7] upper select low enables upper lane
// [R8] chip enable low needed for any access
// [R9] one bank output enable low picks bank
// [R10] both or neither output enable: outputs float
// [R11] single array: output enables driven together
// [R12] single array: write enables driven together
// [R13] one enable may be tied low instead
// [R14] parity bit travels with each byte
// [R15] disabled or unselected: lanes float, no write
// [R16] read needs enable, select, one oe, no we
// [R17] two banks: write only the chosen bank
// [R18] both write enables low: write both banks
// [R19] writes ignore output enables
// [R20] chip enable may end a write
// [R21] unselected lanes and banks stay unchanged
package ccds_pkg;
    localparam int ADDR_W = 13;
    localparam int DATA_W = 16;
    localparam int PAR_W = 2;
    localparam int CLK_NS = 20;
    // minimum times in ns, rounded up to cycles
    localparam int ALE_NS = 10;
    localparam int ASETUP_NS = 6;
    localparam int AHOLD_NS = 5;
    localparam int WPULSE_NS = 25;
    localparam int RACC_NS = 35;
    localparam int HIZ_NS = 25;
    localparam int ALE_CYC = (ALE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ASETUP_CYC = (ASETUP_NS + CLK_NS - 1) / CLK_NS;
    localparam int AHOLD_CYC = (AHOLD_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPULSE_CYC = (WPULSE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RACC_CYC = (RACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int HIZ_CYC = (HIZ_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] CNT_ONE = 4'h1;
    // read lanes pass two flops before capture
    localparam int SYNC_CYC = 2;

    typedef struct packed {
        logic write;
        logic [1:0] bank_sel;     // bit0 bank a, bit1 bank b
        logic [1:0] byte_sel;     // bit0 lower, bit1 upper
        logic [ADDR_W-1:0] word_address;
        logic [DATA_W-1:0] wdata;
        logic [PAR_W-1:0] wpar;
    } ccds_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
        logic [PAR_W-1:0] rpar;
    } ccds_rsp_s;

    typedef struct packed {
        logic addr_latch_open;
        logic [ADDR_W-1:0] word_address;
        logic chip_enable_n;
        logic lower_byte_select_n;
        logic upper_byte_select_n;
        logic bank_a_output_enable_n;
        logic bank_b_output_enable_n;
        logic bank_a_write_enable_n;
        logic bank_b_write_enable_n;
        logic dual_mode;
    } ccds_pins_s;
endpackage : ccds_pkg

// [tb/ccds_dev_model.sv]
`timescale 1ns/10ps
module ccds_dev_model (
    input wire ccds_pkg::ccds_pins_s pins_i,
    input wire logic [ccds_pkg::DATA_W-1:0] host_data_i,
    input wire logic host_data_oe_i,
    input wire logic [ccds_pkg::PAR_W-1:0] host_par_i,
    input wire logic host_par_oe_i,
    output logic [ccds_pkg::DATA_W-1:0] data_o,
    output logic [ccds_pkg::PAR_W-1:0] par_o
);
    import ccds_pkg::*;
    logic [17:0] mem [0:8191];
    logic [ADDR_W-1:0] lat, snap_a, rd_a;
    logic [17:0] junk, m, snap_m, snap_d, rd_m, bus;
    logic snap_ok, snap_wa, snap_wb, rd_ok, wr_act;
    wire dual = pins_i.dual_mode;
    wire ce_n = pins_i.chip_enable_n;
    wire sl = !pins_i.lower_byte_select_n;
    wire su = !pins_i.upper_byte_select_n;
    wire oea = pins_i.bank_a_output_enable_n;
    wire oeb = pins_i.bank_b_output_enable_n;
    wire wea = pins_i.bank_a_write_enable_n;
    wire web = pins_i.bank_b_write_enable_n;
    wire [ADDR_W-1:0] ia = {1'b0, snap_a[11:0]};
    wire [ADDR_W-1:0] ib = {1'b1, snap_a[11:0]};
    function automatic logic [17:0] mrg(input logic [17:0] o, d, k);
        return (o & ~k) | (d & k);
    endfunction : mrg
    initial
    begin
        junk = 18'h2aaaa;
        snap_ok = 1'b0;
        for (int i = 0; i < 8192; i++)
        begin
            mem[i] = 18'h00000;
        end
    end
    // released lanes show a changing pattern, never the last value
    always #7 junk = ~junk;
    always_latch
    begin
        if (pins_i.addr_latch_open)
        begin
            lat <= pins_i.word_address;
        end
    end
    assign m = {su, sl, {8{su}}, {8{sl}}};
    assign wr_act = !ce_n && (sl || su)
        && (dual ? (!wea || !web) : (!wea && !web));
    always @*
    begin
        if (wr_act === 1'b1)
        begin
            snap_a = lat;
            snap_m = m;
            snap_d = {host_par_i, host_data_i};
            snap_wa = !wea;
            snap_wb = !web;
            snap_ok = 1'b1;
        end
    end
    always @(negedge wr_act)
    begin
        if (snap_ok)
        begin
            if (!dual)
            begin
                mem[snap_a] = mrg(mem[snap_a], snap_d, snap_m);
            end
            else
            begin
                if (snap_wa)
                begin
                    mem[ia] = mrg(mem[ia], snap_d, snap_m);
                end
                if (snap_wb)
                begin
                    mem[ib] = mrg(mem[ib], snap_d, snap_m);
                end
            end
            snap_ok = 1'b0;
        end
    end
    assign rd_ok = !ce_n && wea && web
        && (dual ? oea != oeb : !oea && !oeb);
    assign rd_a = dual ? {oea, lat[11:0]} : lat;
    assign rd_m = rd_ok ? m : 18'h00000;
    assign bus = (rd_m & mem[rd_a]) | (~rd_m & junk);
    assign data_o = host_data_oe_i ? host_data_i : bus[15:0];
    assign par_o = host_par_oe_i ? host_par_i : bus[17:16];
endmodule : ccds_dev_model

// [tb/ccds_host_test.sv]
`timescale 1ns/10ps
module ccds_host_test;
    import ccds_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic dual_mode_i = 1'b1;
    logic req_valid_i = 1'b0;
    ccds_req_s req_i = '0;
    logic req_ready_o, rsp_valid_o, d_oe, p_oe;
    ccds_rsp_s rsp_o;
    ccds_pins_s pins;
    logic [DATA_W-1:0] d_in, d_out;
    logic [PAR_W-1:0] p_in, p_out;
    logic [17:0] ref_mem [0:8191];
    logic [31:0] seed = 32'h0fe7;
    int fail_count = 0;
    int compares = 0;
    always #10 ref_clk_i = ~ref_clk_i;
    ccds_host ccds_host_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .dual_mode_i(dual_mode_i), .req_valid_i(req_valid_i),
        .req_ready_o(req_ready_o), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
        .rsp_o(rsp_o), .pins_o(pins), .data_lanes_i(d_in),
        .data_lanes_o(d_out), .data_lanes_oe_o(d_oe), .parity_lanes_i(p_in),
        .parity_lanes_o(p_out), .parity_lanes_oe_o(p_oe));
    ccds_dev_model ccds_dev_model_i (.pins_i(pins), .host_data_i(d_out),
        .host_data_oe_i(d_oe), .host_par_i(p_out), .host_par_oe_i(p_oe),
        .data_o(d_in), .par_o(p_in));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic [17:0] lmask(input logic [1:0] bs);
        return {bs[1], bs[0], {8{bs[1]}}, {8{bs[0]}}};
    endfunction : lmask
    task close_out;
        if (fail_count == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : close_out
    task wait_ready;
        for (int i = 0; i < 60; i++)
        begin
            @(negedge ref_clk_i);
            if (req_ready_o === 1'b1)
                return;
        end
        fail_count++;
        $display("BAD req_ready_o exp 1 seen %b", req_ready_o);
        close_out();
    endtask : wait_ready
    task op(input logic w, input logic [1:0] bk, bs, input logic [12:0] a,
            input logic [17:0] d);
        logic [12:0] ix;
        logic [17:0] ex;
        wait_ready();
        @(posedge ref_clk_i);
        req_valid_i <= 1'b1;
        req_i <= {w, bk, bs, a, d[15:0], d[17:16]};
        wait_ready();
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        if (w && !dual_mode_i)
            ref_mem[a] = (ref_mem[a] & ~lmask(bs)) | (d & lmask(bs));
        for (int b = 0; b < 2; b++)
        begin
            ix = {b[0], a[11:0]};
            if (w && dual_mode_i && bk[b])
                ref_mem[ix] = (ref_mem[ix] & ~lmask(bs)) | (d & lmask(bs));
        end
        if (w)
            return;
        ex = ref_mem[dual_mode_i ? {bk[1], a[11:0]} : a] & lmask(bs);
        for (int i = 0; i < 40; i++)
        begin
            @(negedge ref_clk_i);
            if (rsp_valid_o === 1'b1)
            begin
                compares++;
                if ({rsp_o.rpar, rsp_o.rdata} !== ex)
                begin
                    fail_count++;
                    $display("BAD rsp_o exp %h seen %h", ex,
                             {rsp_o.rpar, rsp_o.rdata});
                end
                return;
            end
        end
        fail_count++;
        $display("BAD rsp_valid_o exp 1 seen %b", rsp_valid_o);
        close_out();
    endtask : op
    task rnd_ops(input int n);
        for (int i = 0; i < n; i++)
        begin
            seed = xs(seed);
            op(seed[0], seed[2:1] == 2'b00 ? 2'b01 : seed[2:1], seed[4:3],
               {seed[5], 8'h00, seed[9:6]}, seed[31:14]);
        end
    endtask : rnd_ops
    initial
    begin
        for (int i = 0; i < 8192; i++)
            ref_mem[i] = 18'h00000;
        repeat (20) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        op(1'b1, 2'b01, 2'b01, 13'h1005, 18'h3a5c3);
        op(1'b1, 2'b10, 2'b11, 13'h0005, 18'h15a96);
        op(1'b1, 2'b11, 2'b10, 13'h0005, 18'h2f0f0);
        op(1'b1, 2'b01, 2'b00, 13'h0005, 18'h3ffff);
        for (int s = 0; s < 4; s++)
        begin
            op(1'b0, 2'b01, s[1:0], 13'h1005, 18'h00000);
            op(1'b0, 2'b10, s[1:0], 13'h0005, 18'h00000);
        end
        rnd_ops(80);
        wait_ready();
        @(posedge ref_clk_i);
        dual_mode_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        op(1'b1, 2'b11, 2'b11, 13'h1005, 18'h0c33c);
        op(1'b1, 2'b11, 2'b11, 13'h0005, 18'h3c3c3);
        op(1'b0, 2'b11, 2'b11, 13'h1005, 18'h00000);
        op(1'b0, 2'b11, 2'b01, 13'h0005, 18'h00000);
        rnd_ops(60);
        close_out();
    end
endmodule : ccds_host_test
